// >>> logic/slf_pkg.sv
// constants for the input filter and linked action block
// assumes a single 50 MHz clock and 16-bit parameter words
package slf_pkg;
    localparam logic [7:0] SLF_CMD_FILTER = 8'h25;
    localparam logic [7:0] SLF_CMD_SET0 = 8'h26;
    localparam logic [7:0] SLF_CMD_SET3 = 8'h29;
    // arbitrary code for the linked-action enable command
    localparam logic [7:0] SLF_CMD_SYNC_EN = 8'h83;
    localparam logic [15:0] SLF_CFG_RST = 16'h0000;
    localparam logic [3:0] SLF_EN_RST = 4'h0;
    localparam int SLF_FE_LSB = 0;
    localparam int SLF_WA_LSB = 8;
    localparam int SLF_WB_LSB = 12;
    localparam int SLF_CAUSE_LSB = 0;
    localparam int SLF_ACT_LSB = 4;
    localparam int SLF_CHAIN_LSB = 9;
    localparam int SLF_REP_BIT = 15;
    localparam int SLF_CLK_MHZ = 50;
    localparam int SLF_DELAY_BASE_NS = 500;
    localparam int SLF_BASE_CYC = SLF_DELAY_BASE_NS * SLF_CLK_MHZ / 1000;
    localparam int SLF_CNT_W = 20;
    localparam int SLF_NSIG = 18;
    localparam int SLF_SIG_EMG = 0;
    localparam int SLF_SIG_LMP = 1;
    localparam int SLF_SIG_LMM = 2;
    localparam int SLF_SIG_H0 = 3;
    localparam int SLF_SIG_H1 = 4;
    localparam int SLF_SIG_INP = 5;
    localparam int SLF_SIG_ALM = 6;
    localparam int SLF_SIG_IO0 = 7;
    localparam int SLF_SIG_IO4 = 11;
    localparam int SLF_SIG_H2 = 15;
    localparam int SLF_SIG_ECA = 16;
    localparam int SLF_SIG_ECB = 17;
endpackage : slf_pkg

// >>> logic/slf_sync_filter.sv
// input noise filters and four linked action sets
// assumes engine events are one-cycle pulses on ref_clk_i
//
// What this block does
// - enable bit picks filtered or pass-through input
// - eight enable bits map onto input groups
// - window A code times groups zero-five
// - window B code times halt2 and encoder
// - delay doubles per code step
// - four sets written by codes 26h-29h
// - cause codes 1-6 select engine events
// - codes 7-F split pulse and io edges
// - action codes 01-04 load compare slot
// - action codes 05-08 save into slot
// - codes 09-12 pulse, drive and stop
// - codes 13-18 speed, timer, split pulse
// - chain mask activates following sets modulo four
// - one-shot sets disable after first firing
// - set enable states readable as status
// - error disables all sets, blocks re-enable
`timescale 1ns/1ps
`default_nettype none
module slf_sync_filter
    import slf_pkg::*;
#(
    parameter int FILT_BASE_CYC = SLF_BASE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] data_write_word_low_i,
    input wire logic emergency_stop_input_i,
    input wire logic plus_limit_input_i,
    input wire logic minus_limit_input_i,
    input wire logic halt_input_0_i,
    input wire logic halt_input_1_i,
    input wire logic halt_input_2_i,
    input wire logic servo_in_position_input_i,
    input wire logic alarm_input_i,
    input wire logic [7:0] general_io_pin_i,
    input wire logic encoder_phase_a_i,
    input wire logic encoder_phase_b_i,
    input wire logic [3:0] compare_true_i,
    input wire logic timer_up_i,
    input wire logic drive_start_i,
    input wire logic const_speed_start_i,
    input wire logic const_speed_end_i,
    input wire logic drive_end_i,
    input wire logic split_start_i,
    input wire logic split_end_i,
    input wire logic split_out_i,
    input wire logic error_flag_i,
    input wire logic error_sync_disable_bit_i,
    output logic emergency_stop_filt_o,
    output logic plus_limit_filt_o,
    output logic minus_limit_filt_o,
    output logic halt_0_filt_o,
    output logic halt_1_filt_o,
    output logic halt_2_filt_o,
    output logic servo_in_position_filt_o,
    output logic alarm_filt_o,
    output logic [7:0] general_io_filt_o,
    output logic encoder_phase_a_filt_o,
    output logic encoder_phase_b_filt_o,
    output logic [3:0] action_fire_o,
    output logic [19:0] response_code_o,
    output logic [3:0] set_enabled_o
);

    // group of each input, as steered by the enable bits
    function automatic int grp_of(input int i);
        int g;
        g = 0;
        if (i == SLF_SIG_EMG) g = 0;
        else if (i <= SLF_SIG_LMM) g = 1;
        else if (i <= SLF_SIG_H1) g = 2;
        else if (i <= SLF_SIG_ALM) g = 3;
        else if (i < SLF_SIG_IO4) g = 4;
        else if (i < SLF_SIG_H2) g = 5;
        else if (i == SLF_SIG_H2) g = 6;
        else g = 7;
        return g;
    endfunction : grp_of

    logic [15:0] cfg_filter;
    logic [15:0] next_cfg_filter;
    logic [15:0] cfg_set [4];
    logic [15:0] next_cfg_set [4];
    logic [3:0] en;
    logic [3:0] next_en;
    logic [3:0] fire;
    logic [3:0] next_fire;
    logic [7:0] io_prev;
    logic [7:0] next_io_prev;
    logic [3:0] cmp_prev;
    logic [3:0] next_cmp_prev;
    logic err_prev;
    logic next_err_prev;

    logic raw [SLF_NSIG];
    logic filt [SLF_NSIG];
    logic [7:0] io_f;
    logic [SLF_CNT_W-1:0] base_w;
    logic [SLF_CNT_W-1:0] thr_a;
    logic [SLF_CNT_W-1:0] thr_b;
    logic [15:0] ev [4];
    logic [3:0] trig;
    logic [3:0] act;
    logic sync_en_cmd;
    logic err_block;

    assign raw[SLF_SIG_EMG] = emergency_stop_input_i;
    assign raw[SLF_SIG_LMP] = plus_limit_input_i;
    assign raw[SLF_SIG_LMM] = minus_limit_input_i;
    assign raw[SLF_SIG_H0] = halt_input_0_i;
    assign raw[SLF_SIG_H1] = halt_input_1_i;
    assign raw[SLF_SIG_INP] = servo_in_position_input_i;
    assign raw[SLF_SIG_ALM] = alarm_input_i;
    assign raw[SLF_SIG_H2] = halt_input_2_i;
    assign raw[SLF_SIG_ECA] = encoder_phase_a_i;
    assign raw[SLF_SIG_ECB] = encoder_phase_b_i;

    // delay count is the base count shifted by the window code
    assign base_w = SLF_CNT_W'(FILT_BASE_CYC);
    assign thr_a = base_w << cfg_filter[SLF_WA_LSB +: 4];
    assign thr_b = base_w << cfg_filter[SLF_WB_LSB +: 4];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_io
            assign raw[SLF_SIG_IO0 + gi] = general_io_pin_i[gi];
            assign io_f[gi] = filt[SLF_SIG_IO0 + gi];
        end
        for (gi = 0; gi < SLF_NSIG; gi++) begin : g_flt
            localparam int G = grp_of(gi);
            logic [2:0] sy;
            logic [2:0] next_sy;
            logic f;
            logic next_f;
            logic [SLF_CNT_W-1:0] c;
            logic [SLF_CNT_W-1:0] next_c;
            logic [SLF_CNT_W-1:0] thr;
            assign thr = (G >= 6) ? thr_b : thr_a;
            always_comb begin
                next_sy = {sy[1:0], raw[gi]};
                next_f = f;
                next_c = '0;
                // a level counts once the last two stages agree
                if (sy[1] == sy[2] && sy[2] != f) begin
                    if (!cfg_filter[SLF_FE_LSB + G]) begin
                        next_f = sy[2];
                    end else if (c >= thr - 1'b1) begin
                        next_f = sy[2];
                    end else begin
                        // any bounce back to the old level restarts the count
                        next_c = c + 1'b1;
                    end
                end
            end
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    sy <= 3'h0;
                    f <= 1'b0;
                    c <= '0;
                end else begin
                    sy <= next_sy;
                    f <= next_f;
                    c <= next_c;
                end
            end
            assign filt[gi] = f;
        end
    endgenerate

    assign emergency_stop_filt_o = filt[SLF_SIG_EMG];
    assign plus_limit_filt_o = filt[SLF_SIG_LMP];
    assign minus_limit_filt_o = filt[SLF_SIG_LMM];
    assign halt_0_filt_o = filt[SLF_SIG_H0];
    assign halt_1_filt_o = filt[SLF_SIG_H1];
    assign halt_2_filt_o = filt[SLF_SIG_H2];
    assign servo_in_position_filt_o = filt[SLF_SIG_INP];
    assign alarm_filt_o = filt[SLF_SIG_ALM];
    assign general_io_filt_o = io_f;
    assign encoder_phase_a_filt_o = filt[SLF_SIG_ECA];
    assign encoder_phase_b_filt_o = filt[SLF_SIG_ECB];

    // trigger events per set, indexed by cause code
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            ev[n] = 16'h0000;
            ev[n][1] = compare_true_i[n] & ~cmp_prev[n];
            ev[n][2] = timer_up_i;
            ev[n][3] = drive_start_i;
            ev[n][4] = const_speed_start_i;
            ev[n][5] = const_speed_end_i;
            ev[n][6] = drive_end_i;
            ev[n][7] = split_start_i;
            ev[n][8] = split_end_i;
            ev[n][9] = split_out_i;
            ev[n][10] = io_f[n] & ~io_prev[n];
            ev[n][11] = ~io_f[n] & io_prev[n];
            ev[n][12] = ev[n][10] & ~io_f[n+4];
            ev[n][13] = ev[n][10] & io_f[n+4];
            ev[n][14] = ev[n][11] & ~io_f[n+4];
            ev[n][15] = ev[n][11] & io_f[n+4];
            trig[n] = en[n] & ev[n][cfg_set[n][SLF_CAUSE_LSB +: 4]];
        end
    end

    // chained sets fire once per cycle; a chained firing does not chain again
    always_comb begin
        act = trig;
        for (int n = 0; n < 4; n++) begin
            for (int k = 1; k < 4; k++) begin
                if (trig[n] && cfg_set[n][SLF_CHAIN_LSB + k - 1]) begin
                    act[(n + k) % 4] = en[(n + k) % 4];
                end
            end
        end
        for (int n = 0; n < 4; n++) begin
            act[n] = act[n] | trig[n];
        end
    end

    assign sync_en_cmd = cmd_write_i && cmd_code_i == SLF_CMD_SYNC_EN;
    assign err_block = error_flag_i && error_sync_disable_bit_i;

    always_comb begin
        next_cfg_filter = cfg_filter;
        for (int n = 0; n < 4; n++) begin
            next_cfg_set[n] = cfg_set[n];
        end
        if (cmd_write_i && cmd_code_i == SLF_CMD_FILTER) begin
            next_cfg_filter = data_write_word_low_i;
        end
        if (cmd_write_i && cmd_code_i >= SLF_CMD_SET0 && cmd_code_i <= SLF_CMD_SET3) begin
            // bits 14-12 are kept as written; the host keeps them zero
            next_cfg_set[2'(cmd_code_i - SLF_CMD_SET0)] = data_write_word_low_i;
        end
    end

    always_comb begin
        next_fire = act;
        next_en = en;
        for (int n = 0; n < 4; n++) begin
            if (act[n] && !cfg_set[n][SLF_REP_BIT]) begin
                next_en[n] = 1'b0;
            end
        end
        // enabling wins over a one-shot clear in the same cycle
        if (sync_en_cmd && !err_block) begin
            next_en = next_en | data_write_word_low_i[3:0];
        end
        if (error_flag_i && !err_prev && error_sync_disable_bit_i) begin
            next_en = 4'h0;
        end
        next_io_prev = io_f;
        next_cmp_prev = compare_true_i;
        next_err_prev = error_flag_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_filter <= SLF_CFG_RST;
            for (int n = 0; n < 4; n++) begin
                cfg_set[n] <= SLF_CFG_RST;
            end
            en <= SLF_EN_RST;
            fire <= 4'h0;
            io_prev <= 8'h00;
            cmp_prev <= 4'h0;
            err_prev <= 1'b0;
        end else begin
            cfg_filter <= next_cfg_filter;
            for (int n = 0; n < 4; n++) begin
                cfg_set[n] <= next_cfg_set[n];
            end
            en <= next_en;
            fire <= next_fire;
            io_prev <= next_io_prev;
            cmp_prev <= next_cmp_prev;
            err_prev <= next_err_prev;
        end
    end

    assign action_fire_o = fire;
    assign set_enabled_o = en;
    // action decode lives in the engines; codes pass through as written
    assign response_code_o = {cfg_set[3][SLF_ACT_LSB +: 5],
                              cfg_set[2][SLF_ACT_LSB +: 5],
                              cfg_set[1][SLF_ACT_LSB +: 5],
                              cfg_set[0][SLF_ACT_LSB +: 5]};

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_oneshot;
        act[0] && !cfg_set[0][SLF_REP_BIT] && !sync_en_cmd |=> !set_enabled_o[0];
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot set stayed on");

    property p_err_clear;
        error_flag_i && !err_prev && error_sync_disable_bit_i |=> set_enabled_o == 4'h0;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error left a set on");

    property p_err_block;
        err_block |=> (set_enabled_o & ~$past(set_enabled_o)) == 4'h0;
    endproperty
    a_err_block: assert property (p_err_block) else $error("set enabled under error");

    property p_fire;
        trig[0] |=> action_fire_o[0] ##1 !action_fire_o[0] || $past(act[0]);
    endproperty
    a_fire: assert property (p_fire) else $error("trigger did not fire");

    property p_chain;
        trig[1] && cfg_set[1][SLF_CHAIN_LSB] && en[2] |=> action_fire_o[2];
    endproperty
    a_chain: assert property (p_chain) else $error("chained set not fired");

    property p_pass;
        !cfg_filter[SLF_FE_LSB] && g_flt[0].sy[1] == g_flt[0].sy[2]
            |=> emergency_stop_filt_o == $past(g_flt[0].sy[2]);
    endproperty
    a_pass: assert property (p_pass) else $error("pass-through lagged");

    property p_hold;
        $past(cfg_filter[SLF_FE_LSB]) && $changed(emergency_stop_filt_o)
            |-> $past(g_flt[0].c) == $past(thr_a) - 1'b1;
    endproperty
    a_hold: assert property (p_hold) else $error("filter accepted early");

    property p_cfg;
        cmd_write_i && cmd_code_i == SLF_CMD_SET0 |=> cfg_set[0] == $past(data_write_word_low_i);
    endproperty
    a_cfg: assert property (p_cfg) else $error("set 0 word not stored");

    property p_status;
        !en[2] ##1 en[2] |-> $past(sync_en_cmd) && $past(data_write_word_low_i[2]);
    endproperty
    a_status: assert property (p_status) else $error("set enabled without command");

endmodule : slf_sync_filter
`default_nettype wire

// >>> dv/slf_host.sv
// host model that writes command codes and parameter words
// assumes the block samples the strobe on the rising edge of ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module slf_host
    import slf_pkg::*;
(
    input wire logic ref_clk_i,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [15:0] data_o
);
    initial begin
        cmd_write_o = 1'b0;
        cmd_code_o = 8'h00;
        data_o = 16'h0000;
    end
    // one strobe per command, held across exactly one sampling edge
    task send(input logic [7:0] code, input logic [15:0] data);
        @(posedge ref_clk_i);
        #1;
        cmd_write_o = 1'b1;
        cmd_code_o = code;
        // set words always carry zero in the reserved bits
        data_o = (code >= SLF_CMD_SET0 && code <= SLF_CMD_SET3) ? (data & 16'h8fff) : data;
        @(posedge ref_clk_i);
        #1;
        cmd_write_o = 1'b0;
    endtask : send
    // re-arming a one-shot set is left to the host
    task enable(input logic [3:0] sets);
        send(SLF_CMD_SYNC_EN, {12'h000, sets});
    endtask : enable
endmodule : slf_host
`default_nettype wire

// >>> dv/test_slf_sync_filter.sv
// self-checking bench for the input filter and linked action block
// assumes slf_host drives the command port; filter base count shortened to 2
`timescale 1ns/1ps
`default_nettype none
module test_slf_sync_filter
    import slf_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data;
    logic emg = 1'b0;
    logic h2 = 1'b0;
    logic [7:0] pt = 8'h00;
    logic [7:0] io = 8'h00;
    logic [8:0] ev = 9'h000;
    logic [2:0] cmp = 3'h0;
    logic err = 1'b0;
    logic esd = 1'b0;
    logic emg_f, lmp_f, lmm_f, h0_f, h1_f, h2_f, inp_f, alm_f, eca_f, ecb_f;
    logic [7:0] io_f;
    logic [3:0] fire, en;
    logic [19:0] resp;
    logic [7:0] pt_f;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int fire_cnt = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    slf_host HOST (.ref_clk_i(ref_clk_i), .cmd_write_o(cmd_write), .cmd_code_o(cmd_code),
        .data_o(cmd_data));
    slf_sync_filter #(.FILT_BASE_CYC(2)) DUT (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_write_i(cmd_write), .cmd_code_i(cmd_code),
        .data_write_word_low_i(cmd_data), .emergency_stop_input_i(emg),
        .plus_limit_input_i(pt[7]), .minus_limit_input_i(pt[6]), .halt_input_0_i(pt[5]),
        .halt_input_1_i(pt[4]), .halt_input_2_i(h2), .servo_in_position_input_i(pt[3]),
        .alarm_input_i(pt[2]), .general_io_pin_i(io), .encoder_phase_a_i(pt[1]),
        .encoder_phase_b_i(pt[0]), .compare_true_i({cmp, ev[0]}), .timer_up_i(ev[1]),
        .drive_start_i(ev[2]), .const_speed_start_i(ev[3]), .const_speed_end_i(ev[4]),
        .drive_end_i(ev[5]), .split_start_i(ev[6]), .split_end_i(ev[7]), .split_out_i(ev[8]),
        .error_flag_i(err), .error_sync_disable_bit_i(esd), .emergency_stop_filt_o(emg_f),
        .plus_limit_filt_o(lmp_f), .minus_limit_filt_o(lmm_f), .halt_0_filt_o(h0_f),
        .halt_1_filt_o(h1_f), .halt_2_filt_o(h2_f), .servo_in_position_filt_o(inp_f),
        .alarm_filt_o(alm_f), .general_io_filt_o(io_f), .encoder_phase_a_filt_o(eca_f),
        .encoder_phase_b_filt_o(ecb_f), .action_fire_o(fire), .response_code_o(resp),
        .set_enabled_o(en));
    assign pt_f = {lmp_f, lmm_f, h0_f, h1_f, inp_f, alm_f, eca_f, ecb_f};
    // the timeout ceiling is far above the few hundred cycles the tests need
    always @(posedge ref_clk_i) begin
        cyc++;
        if (fire[0] === 1'b1) fire_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    task pulse(input int k);
        ev[k] = 1'b1;
        tick(1);
        ev[k] = 1'b0;
    endtask : pulse
    task t_config;
        HOST.send(8'h26, 16'h0010);
        HOST.send(8'h27, 16'h00a0);
        HOST.send(8'h28, 16'h0110);
        HOST.send(8'h29, 16'h0180);
        check("response codes", resp, {5'h18, 5'h11, 5'h0a, 5'h01});
        check("enables after reset", en, 4'h0);
        $display("test config done");
    endtask : t_config
    task t_oneshot;
        HOST.send(SLF_CMD_SET0, 16'h0033);
        HOST.enable(4'h1);
        check("enabled", en, 4'h1);
        pulse(2);
        check("fire next cycle", fire, 4'h1);
        tick(1);
        check("single cycle fire", fire, 4'h0);
        check("self disabled", en, 4'h0);
        pulse(2);
        check("no second fire", fire, 4'h0);
        HOST.enable(4'h1);
        check("re-enabled", en, 4'h1);
        $display("test oneshot done");
    endtask : t_oneshot
    task t_chain;
        HOST.send(8'h27, 16'h8202);
        HOST.send(8'h28, 16'h8000);
        HOST.enable(4'h6);
        repeat (2) begin
            pulse(1);
            check("chained fire", fire, 4'h6);
            tick(1);
            check("repeat keeps enabled", en, 4'h7);
        end
        // each set watches only its own compare slot
        HOST.send(SLF_CMD_SET3, 16'h8001);
        HOST.enable(4'h8);
        cmp = 3'h7;
        tick(1);
        cmp = 3'h0;
        check("own compare slot", fire, 4'h8);
        $display("test chain done");
    endtask : t_chain
    task t_error;
        esd = 1'b1;
        err = 1'b1;
        tick(2);
        check("error disables", en, 4'h0);
        HOST.enable(4'hf);
        check("enable refused", en, 4'h0);
        err = 1'b0;
        HOST.enable(4'hf);
        check("enable after clear", en, 4'hf);
        esd = 1'b0;
        $display("test error done");
    endtask : t_error
    task t_causes;
        int base;
        for (int k = 1; k <= 9; k++) begin
            HOST.send(SLF_CMD_SET0, 16'h8000 | 16'(k));
            HOST.enable(4'h1);
            base = fire_cnt;
            ev = 9'h001 << (k - 1);
            tick(1);
            ev = 9'h000;
            tick(2);
            check("cause code fires", fire_cnt - base, 1);
        end
        $display("test causes done");
    endtask : t_causes
    task t_io_edges;
        int base;
        logic [1:0] want [6] = '{2'd2, 2'd2, 2'd1, 2'd1, 2'd1, 2'd1};
        for (int c = 10; c <= 15; c++) begin
            HOST.send(SLF_CMD_SET0, 16'h8000 | 16'(c));
            base = fire_cnt;
            for (int p = 0; p < 2; p++) begin
                io[4] = p[0];
                tick(8);
                io[0] = 1'b1;
                tick(8);
                check("io pass-through", io_f, {3'b000, p[0], 4'b0001});
                io[0] = 1'b0;
                tick(8);
            end
            check("io edge fires", fire_cnt - base, 32'(want[c - 10]));
        end
        io = 8'h00;
        $display("test io edges done");
    endtask : t_io_edges
    task t_filter;
        int seen;
        HOST.send(SLF_CMD_FILTER, 16'h0241);
        emg = 1'b1;
        h2 = 1'b1;
        tick(6);
        emg = 1'b0;
        h2 = 1'b0;
        seen = 0;
        for (int i = 0; i < 20; i++) begin
            if (h2_f === 1'b1) seen = 1;
            tick(1);
        end
        check("window b passes 6 cycles", seen, 1);
        check("window a rejects 6 cycles", emg_f, 1'b0);
        emg = 1'b1;
        tick(8);
        check("held too short", emg_f, 1'b0);
        tick(2);
        check("still counting", emg_f, 1'b0);
        tick(1);
        check("accepted after delay", emg_f, 1'b1);
        emg = 1'b0;
        tick(30);
        $display("test filter done");
    endtask : t_filter
    task t_pass;
        pt = 8'hff;
        tick(3);
        check("pass not yet", pt_f, 8'h00);
        tick(1);
        check("pass after four", pt_f, 8'hff);
        pt = 8'h00;
        tick(6);
        // servo_in_position_input, alarm and encoders filtered; limits and halts still pass through
        HOST.send(SLF_CMD_FILTER, 16'h0088);
        pt = 8'hff;
        tick(4);
        check("filtered groups lag", pt_f, 8'hf0);
        tick(1);
        check("filtered after base delay", pt_f, 8'hff);
        pt = 8'h00;
        $display("test pass-through done");
    endtask : t_pass
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        tick(3);
        rst_i = 1'b0;
        check("filter outputs reset", {emg_f, lmp_f, h2_f, io_f}, 11'h000);
        t_config();
        t_oneshot();
        t_chain();
        t_error();
        t_causes();
        t_io_edges();
        t_filter();
        t_pass();
        wrap_up();
    end
endmodule : test_slf_sync_filter
`default_nettype wire
